// File: ipcf_chan.v
// One input point: pin synchroniser, on/off delay filter and rising edge pulse
`timescale 1ns/1ns
`include "ipcf_consts.vh"

module ipcf_chan (
  input wire aclk,
  input wire aresetn,
  input wire pin,
  input wire tick_ms,
  input wire [`IPCF_MS_W-1:0] limit_ms,
  output reg filtered,
  output reg rise
);

  reg sync1;
  reg sync2;
  reg last;
  reg [`IPCF_MS_W-1:0] age_ms;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last <= 1'b0;
      rise <= 1'b0;
      filtered <= 1'b0;
      age_ms <= {`IPCF_MS_W{1'b0}};
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      last <= sync2;
      rise <= sync2 & ~last;
      // Age restarts on any raw change
      if (sync2 != last) begin
        age_ms <= {`IPCF_MS_W{1'b0}};
      end else if (tick_ms && age_ms != {`IPCF_MS_W{1'b1}}) begin
        age_ms <= age_ms + {{(`IPCF_MS_W-1){1'b0}}, 1'b1};
      end
      // Strictly past the delay, first tick may be partial; both directions
      if (sync2 == last && (age_ms > limit_ms || limit_ms == {`IPCF_MS_W{1'b0}})) begin
        filtered <= last;
      end
    end
  end

endmodule

// File: ipcf_consts.vh
// Register map, reset values and timing constants of the input conditioning block
`ifndef IPCF_CONSTS_VH
`define IPCF_CONSTS_VH

`define IPCF_OFS_CATCH_SEL 8'h00
`define IPCF_OFS_FILT_G0 8'h04
`define IPCF_OFS_FILT_G1 8'h08
`define IPCF_OFS_SCAN 8'h0c
`define IPCF_OFS_IMAGE 8'h10
`define IPCF_OFS_LEVEL 8'h14

`define IPCF_CATCH_SEL_RST 8'h00
`define IPCF_FILT_CODE_W 4
`define IPCF_FILT_CODE_RST 4'h4
`define IPCF_FILT_CODE_MAX 4'ha
`define IPCF_MS_W 11

`define IPCF_GROUP_SIZE 7
`define IPCF_CLK_NS 8
`define IPCF_TICK_NS 1000000
`define IPCF_TICK_CYCLES (`IPCF_TICK_NS / `IPCF_CLK_NS)

`define IPCF_RESP_OKAY 2'h0
`define IPCF_RESP_SLVERR 2'h2

`endif

// File: ipcf_field.sv
// Field device model driving the eight input contacts
`timescale 1ns/1ns
module ipcf_field (
  input wire aclk,
  input wire [7:0] base,
  input wire [7:0] plen,
  input wire go,
  output reg [7:0] pins = 8'h00
);
  reg [7:0] cnt = 8'h00;
  // Inverted levels for plen cycles after go
  always @(posedge aclk) begin
    if (go) cnt <= plen;
    else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    pins <= (cnt != 8'h00) ? ~base : base;
  end
endmodule

// File: ipcf_top.v
// Pulse catch and input filter for the eight built-in input points, AXI4-Lite slave
`timescale 1ns/1ns
`include "ipcf_consts.vh"

// Notes on behaviour
// - Points 0-1 catch pulses down to 10 us
// - Points 2-7 catch pulses of 50 us
// - Caught pulse shows one scan, then clears
// - Catch exists only on eight built-in points
// - Unselected points act as plain filtered inputs
// - Filter delays both edges, rejects short changes
// - Filter codes 0..1000 ms, default 10 ms
// - One filter time for points 0-6, another for point 7
// - Group filter applies to every point's level; catch path bypasses it
module ipcf_top #(
  parameter NUM_POINTS = 8,
  parameter TICK_CYCLES = `IPCF_TICK_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire [NUM_POINTS-1:0] builtin_input_points,
  output reg [NUM_POINTS-1:0] input_image,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // Filter code to delay in milliseconds
  function [`IPCF_MS_W-1:0] code_ms;
    input [`IPCF_FILT_CODE_W-1:0] code;
    begin
      case (code)
        4'h0: code_ms = 11'd0;
        4'h1: code_ms = 11'd1;
        4'h2: code_ms = 11'd2;
        4'h3: code_ms = 11'd5;
        4'h4: code_ms = 11'd10;
        4'h5: code_ms = 11'd20;
        4'h6: code_ms = 11'd50;
        4'h7: code_ms = 11'd100;
        4'h8: code_ms = 11'd200;
        4'h9: code_ms = 11'd500;
        default: code_ms = 11'd1000;
      endcase
    end
  endfunction

  // Register decode shared by read and write paths
  function mapped;
    input [7:0] addr;
    begin
      case (addr)
        `IPCF_OFS_CATCH_SEL, `IPCF_OFS_FILT_G0, `IPCF_OFS_FILT_G1,
        `IPCF_OFS_SCAN, `IPCF_OFS_IMAGE, `IPCF_OFS_LEVEL: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  reg [NUM_POINTS-1:0] catch_sel;
  reg [`IPCF_FILT_CODE_W-1:0] filt_g0;
  reg [`IPCF_FILT_CODE_W-1:0] filt_g1;
  reg [NUM_POINTS-1:0] pending;
  reg scan_pulse;
  reg tick_ms;
  reg [31:0] tick_cnt;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire [NUM_POINTS-1:0] level;
  wire [NUM_POINTS-1:0] rise;
  wire [`IPCF_MS_W-1:0] ms_g0;
  wire [`IPCF_MS_W-1:0] ms_g1;
  wire do_write;

  assign ms_g0 = code_ms(filt_g0);
  assign ms_g1 = code_ms(filt_g1);
  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  // Millisecond tick
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 32'h0;
      tick_ms <= 1'b0;
    end else if (tick_cnt >= TICK_CYCLES - 1) begin
      tick_cnt <= 32'h0;
      tick_ms <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick_ms <= 1'b0;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_POINTS; i = i + 1) begin : g_pt
      ipcf_chan u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(builtin_input_points[i]),
        .tick_ms(tick_ms),
        .limit_ms((i < `IPCF_GROUP_SIZE) ? ms_g0 : ms_g1),
        .filtered(level[i]),
        .rise(rise[i])
      );

      // Catch, then one scan on, one scan back to the level
      always @(posedge aclk) begin
        if (!aresetn) begin
          pending[i] <= 1'b0;
          input_image[i] <= 1'b0;
        end else begin
          if (catch_sel[i] && rise[i]) begin
            pending[i] <= 1'b1;
          end else if (scan_pulse) begin
            pending[i] <= 1'b0;
          end
          if (scan_pulse) begin
            input_image[i] <= (catch_sel[i] & pending[i]) | level[i];
          end
        end
      end
    end
  endgenerate

  // Write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IPCF_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      catch_sel <= `IPCF_CATCH_SEL_RST;
      filt_g0 <= `IPCF_FILT_CODE_RST;
      filt_g1 <= `IPCF_FILT_CODE_RST;
      scan_pulse <= 1'b0;
    end else begin
      scan_pulse <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_held && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? `IPCF_RESP_OKAY : `IPCF_RESP_SLVERR;
        if (w_strb[0]) begin
          case (aw_addr)
            `IPCF_OFS_CATCH_SEL: catch_sel <= w_data[NUM_POINTS-1:0];
            `IPCF_OFS_FILT_G0: begin
              if (w_data[`IPCF_FILT_CODE_W-1:0] <= `IPCF_FILT_CODE_MAX) begin
                filt_g0 <= w_data[`IPCF_FILT_CODE_W-1:0];
              end
            end
            `IPCF_OFS_FILT_G1: begin
              if (w_data[`IPCF_FILT_CODE_W-1:0] <= `IPCF_FILT_CODE_MAX) begin
                filt_g1 <= w_data[`IPCF_FILT_CODE_W-1:0];
              end
            end
            `IPCF_OFS_SCAN: scan_pulse <= 1'b1;
            default: scan_pulse <= 1'b0;
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `IPCF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `IPCF_RESP_OKAY : `IPCF_RESP_SLVERR;
      case (s_axi_araddr)
        `IPCF_OFS_CATCH_SEL: s_axi_rdata <= {{(32-NUM_POINTS){1'b0}}, catch_sel};
        `IPCF_OFS_FILT_G0: s_axi_rdata <= {{(32-`IPCF_FILT_CODE_W){1'b0}}, filt_g0};
        `IPCF_OFS_FILT_G1: s_axi_rdata <= {{(32-`IPCF_FILT_CODE_W){1'b0}}, filt_g1};
        `IPCF_OFS_IMAGE: s_axi_rdata <= {{(32-NUM_POINTS){1'b0}}, input_image};
        `IPCF_OFS_LEVEL: s_axi_rdata <= {{(32-NUM_POINTS){1'b0}}, level};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// File: ipcf_top_chk.sv
// Port checker for the input conditioning block
`timescale 1ns/1ns
module ipcf_top_chk #(
  parameter NUM_POINTS = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [NUM_POINTS-1:0] input_image,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  b_after_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late");
  r_after_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
  unmapped_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("unmapped read returned data");
  image_scan_a: assert property ($changed(input_image) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("image changed outside a scan");
endmodule
bind ipcf_top ipcf_top_chk #(.NUM_POINTS(NUM_POINTS)) chk (.aclk(aclk), .aresetn(aresetn),
  .input_image(input_image), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: ipcf_top_tb.sv
// Testbench for the pulse catch and input filter block
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t got %h expected %h", $time, g, e); end end
module ipcf_top_tb;
  reg aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00, base = 8'h00, plen = 8'h00;
  reg [31:0] wdata = 32'h0, rv;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg [1:0] br, rr;
  wire [7:0] pins, input_image;
  wire [31:0] rdata;
  wire [1:0] bresp, rresp;
  wire awready, wready, bvalid, arready, rvalid;
  integer err_total = 0, samples_checked = 0, i;
  always #4 aclk = ~aclk;
  ipcf_field field (.aclk(aclk), .base(base), .plen(plen), .go(go), .pins(pins));
  ipcf_top #(.TICK_CYCLES(10)) uut (.aclk(aclk), .aresetn(aresetn), .builtin_input_points(pins),
    .input_image(input_image), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task wr(input [7:0] a, input [31:0] d);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bready && bvalid) begin
          bready <= 1'b0;
          br = bresp;
        end
      end while (awvalid || wvalid || bready);
    end
  endtask
  task rd(input [7:0] a);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rready && rvalid) begin
          rready <= 1'b0;
          rv = rdata;
          rr = rresp;
        end
      end while (arvalid || rready);
    end
  endtask
  task scan;
    begin
      wr(8'h0c, 32'h1);
      repeat (2) @(posedge aclk);
    end
  endtask
  task pulse(input [7:0] len);
    begin
      plen <= len;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
    end
  endtask
  task t_regs;
    begin
      rd(8'h00);
      `CHK({rr, rv}, 34'h0)
      rd(8'h04);
      `CHK({rr, rv}, 34'h4)
      rd(8'h08);
      `CHK({rr, rv}, 34'h4)
      rd(8'h18);
      `CHK({rr, rv}, {2'h2, 32'h0})
      wr(8'h18, 32'h1);
      `CHK(br, 2'h2)
      for (i = 0; i < 11; i++) begin
        wr(8'h08, i);
        rd(8'h08);
        `CHK(rv, i[31:0])
      end
      wr(8'h08, 32'hb);
      rd(8'h08);
      `CHK(rv, 32'ha)
      $display("t_regs done");
    end
  endtask
  task t_catch;
    begin
      wr(8'h00, 32'h7e);
      pulse(8'h03);
      repeat (10) @(posedge aclk);
      `CHK(input_image, 8'h00)
      scan;
      `CHK(input_image, 8'h7e)
      scan;
      `CHK(input_image, 8'h00)
      $display("t_catch done");
    end
  endtask
  task t_filter;
    begin
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h1);
      wr(8'h08, 32'h3);
      pulse(8'h09);
      repeat (12) @(posedge aclk);
      rd(8'h14);
      `CHK(rv, 32'h0)
      repeat (28) @(posedge aclk);
      rd(8'h14);
      `CHK(rv, 32'h0)
      base <= 8'hff;
      repeat (26) @(posedge aclk);
      rd(8'h14);
      `CHK(rv, 32'h7f)
      repeat (40) @(posedge aclk);
      rd(8'h14);
      `CHK(rv, 32'hff)
      base <= 8'h00;
      repeat (30) @(posedge aclk);
      rd(8'h14);
      `CHK(rv, 32'h80)
      scan;
      `CHK(input_image, 8'h80)
      wr(8'h04, 32'h0);
      base <= 8'hff;
      repeat (6) @(posedge aclk);
      rd(8'h14);
      `CHK(rv[6:0], 7'h7f)
      $display("t_filter done");
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs;
    t_catch;
    t_filter;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    finish_test;
  end
endmodule
